// ### pfa_pkg.sv
// Shared constants and carriers for the program flash access controller.
// Assumes a 200 MHz system clock and an 8-bit register port from the CPU core.
package pfa_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Array geometry
   localparam int WORD_W = 14;
   localparam int ROW_AW = 5;
   localparam int ARR_AW = 14;
   localparam int ADDR_W = 15;
   localparam logic [13:0] ERASED_WORD = 14'h3fff;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_KEY = 4'h1;
   localparam logic [3:0] OFS_ADDR_LO = 4'h2;
   localparam logic [3:0] OFS_ADDR_HI = 4'h3;
   localparam logic [3:0] OFS_DATA_LO = 4'h4;
   localparam logic [3:0] OFS_DATA_HI = 4'h5;
   localparam logic [3:0] OFS_PTR_LO = 4'h6;
   localparam logic [3:0] OFS_PTR_HI = 4'h7;
   localparam logic [3:0] OFS_IND_DATA = 4'h8;
   localparam logic [3:0] OFS_STATUS = 4'h9;

   // Control register bits
   localparam int CTL_RD = 0;
   localparam int CTL_WR = 1;
   localparam int CTL_WALLOW = 2;
   localparam int CTL_ERASE = 3;
   localparam int CTL_LATCH = 4;
   localparam int CTL_SPACE = 6;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // Status register bits
   localparam int STS_FLAG = 0;
   localparam int STS_IEN = 1;
   localparam int STS_BUSY = 2;
   localparam int STS_CP = 3;

   // Unlock keys
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'haa;

   ////////////////////////////////////////////////////////////////////////////
   // Write protect ranges and configuration space map
   localparam logic [1:0] WRT_ALL = 2'b00;
   localparam logic [1:0] WRT_HALF = 2'b01;
   localparam logic [1:0] WRT_BOOT = 2'b10;
   localparam logic [12:0] WRT_HALF_TOP = 13'h0fff;
   localparam logic [12:0] WRT_BOOT_TOP = 13'h01ff;
   localparam logic [3:0] UID_LAST = 4'h3;
   localparam logic [3:0] REV_ADDR = 4'h5;
   localparam logic [3:0] DEV_ADDR = 4'h6;

   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int TICK_NS = 1000;
   localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ERASE_TIME_US = 4;
   localparam int PROG_TIME_US = 2;
   localparam logic [7:0] ERASE_TICKS = 8'((ERASE_TIME_US * 1000) / TICK_NS);
   localparam logic [7:0] PROG_TICKS = 8'((PROG_TIME_US * 1000) / TICK_NS);

   ////////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } pfa_bus_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic bulk;
      logic [13:0] addr;
      logic [13:0] wdata;
   } pfa_pgm_t;

endpackage : pfa_pkg

// ### pfa_mem.sv
// Simple one-write one-read word memory with registered read data.
// Assumes the caller keeps write and read addresses in range.
`timescale 1ns/1ps
module pfa_mem #(
   parameter int W = 14,
   parameter int AW = 5
) (
   input wire logic mclk_in,            // System clock
   input wire logic we_in,              // Write enable
   input wire logic [AW-1:0] waddr_in,  // Write address
   input wire logic [W-1:0] wdata_in,   // Write data
   input wire logic [AW-1:0] raddr_in,  // Read address
   output logic [W-1:0] rdata_out       // Read data, one cycle after address
);
   logic [W-1:0] mem_q [0:(1<<AW)-1];

   // Array has no reset; contents are whatever was last written
   always_ff @(posedge mclk_in) begin
      if (we_in) begin
         mem_q[waddr_in] <= wdata_in;
      end
      rdata_out <= mem_q[raddr_in];
   end
endmodule : pfa_mem

// ### pfa_tmr.sv
// Operation timer: one microsecond tick divider and a tick countdown.
// Assumes start is a one-cycle pulse while the timer is idle.
`timescale 1ns/1ps
module pfa_tmr
   import pfa_pkg::*;
(
   input wire logic mclk_in,      // System clock
   input wire logic sys_rst_in,   // Async reset, active high
   input wire logic start_in,     // Start pulse
   input wire logic [7:0] ticks_in, // Duration in ticks
   output logic done_out          // One-cycle pulse at expiry
);
   import pfa_pkg::*;
   logic [15:0] div_q, div_d;
   logic [7:0] cnt_q, cnt_d;
   logic run_q, run_d;
   logic done_d;

   // Divider restarts with each operation so the length is exact
   always_comb begin
      div_d = div_q;
      cnt_d = cnt_q;
      run_d = run_q;
      done_d = 1'b0;
      if (start_in) begin
         div_d = 16'(TICK_CYC - 1);
         cnt_d = ticks_in;
         run_d = 1'b1;
      end else if (run_q) begin
         if (div_q == 16'h0000) begin
            div_d = 16'(TICK_CYC - 1);
            if (cnt_q <= 8'h01) begin
               run_d = 1'b0;
               done_d = 1'b1;
            end else begin
               cnt_d = cnt_q - 8'h01;
            end
         end else begin
            div_d = div_q - 16'h0001;
         end
      end
   end

   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         div_q <= 16'h0000;
         cnt_q <= 8'h00;
         run_q <= 1'b0;
         done_out <= 1'b0;
      end else begin
         div_q <= div_d;
         cnt_q <= cnt_d;
         run_q <= run_d;
         done_out <= done_d;
      end
   end
endmodule : pfa_tmr

// ### pfa_ctrl.sv
// Program flash access controller: register port, unlock, read/erase/program
// sequencer, protection and an on-chip programmer port.
// Assumes the CPU core halts while cpu_stall_out is high and that the
// programmer port runs on the same clock.
//
// What this block does
// - Flash is 14-bit words, 32-word erase rows
// - Erase sets ones; self-programming only clears bits
// - Hidden row latches loaded through data pair
// - Pointer read: one byte, one stalled cycle
// - Pointer path never writes or erases flash
// - Space select picks main or configuration space
// - Read trigger stalls, then data pair holds word
// - Data pair holds until read or write
// - Read trigger clears itself when done
// - Erase, load and write need full unlock
// - Write trigger stalls CPU until operation ends
// - Protected targets refuse register-port writes
// - Own timer sets erase and write time
// - Code protect blocks programmer; bulk erase clears
// - Protect range bars only self write/erase
// - No bulk erase from self-programming
// - User ID writable; IDs and config read-only
// - Protected row: trigger clears, no erase
// - Erase end sets flag, irq; latches kept
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module pfa_ctrl
   import pfa_pkg::*;
#(
   parameter logic [13:0] REV_ID = 14'h2001,  // Arbitrary revision code
   parameter logic [13:0] DEV_ID = 14'h1234   // Arbitrary device code
) (
   input wire logic mclk_in,                  // System clock
   input wire logic sys_rst_in,               // Async reset, active high
   input wire pfa_pkg::pfa_bus_t bus_in,      // CPU register port request
   output logic [7:0] rd_data_out,            // Read data, cycle after strobe
   output logic cpu_stall_out,                // CPU suspend
   output logic irq_out,                      // Completion interrupt level
   input wire logic [1:0] cfg_wrt_in,         // Write protect range field
   input wire logic cfg_code_protect_in,      // Code protect fuse, high = on
   input wire pfa_pkg::pfa_pgm_t pgm_in,      // External programmer request
   output logic [13:0] pgm_rdata_out          // Programmer read data
);
   import pfa_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE, ST_RD, ST_RD_CAP, ST_ER, ST_PG_RD, ST_PG_WR, ST_WAIT, ST_BULK
   } pfa_st_t;
   typedef enum logic [1:0] {KEY_IDLE, KEY_ONE, KEY_TWO} pfa_key_t;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Word index in the array: configuration space sits in the upper half
   function automatic logic [13:0] arr_addr(input logic space, input logic [14:0] a);
      return {space, a[12:0]};
   endfunction : arr_addr

   // Self write or erase refused for this target
   function automatic logic wr_refused(input logic space, input logic [14:0] a,
                                       input logic [1:0] wrt);
      logic hit;
      hit = 1'b0;
      if (space) begin
         hit = (a[14:4] != 11'h000) || (a[3:0] > UID_LAST);
      end else begin
         unique case (wrt)
            WRT_ALL: hit = 1'b1;
            WRT_HALF: hit = (a[12:0] <= WRT_HALF_TOP);
            WRT_BOOT: hit = (a[12:0] <= WRT_BOOT_TOP);
            default: hit = 1'b0;
         endcase
      end
      return hit;
   endfunction : wr_refused

   ////////////////////////////////////////////////////////////////////////////
   // State

   pfa_st_t st_q, st_d;
   pfa_key_t key_q, key_d;
   logic [7:0] ctl_q, ctl_d;
   logic [14:0] addr_q, addr_d;
   logic [13:0] data_q, data_d;
   logic [15:0] ptr_q, ptr_d;
   logic [13:0] idx_q, idx_d;
   logic flag_q, flag_d;
   logic ien_q, ien_d;
   logic cp_q, cp_d;
   logic cp_init_q, cp_init_d;
   logic bulk_q, bulk_d;
   logic stall_d, irq_d;
   logic [7:0] rdata_d;
   logic pgm_rd_q;
   logic [13:0] pgm_rdata_d;

   // Array and latch ports
   logic fl_we, lt_we;
   logic [13:0] fl_waddr, fl_raddr, fl_wdata, fl_rdata;
   logic [4:0] lt_waddr;
   logic [13:0] lt_wdata, lt_rdata;
   logic tmr_start;
   logic [7:0] tmr_ticks;
   logic tmr_done;
   logic [13:0] row_base;
   logic bus_w, bus_r;

   assign bus_w = bus_in.wr;
   assign bus_r = bus_in.rd;
   assign row_base = arr_addr(ctl_q[CTL_SPACE], addr_q) & 14'h3fe0;

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer, unlock and register writes
   always_comb begin
      st_d = st_q;
      key_d = key_q;
      ctl_d = ctl_q;
      addr_d = addr_q;
      data_d = data_q;
      ptr_d = ptr_q;
      idx_d = idx_q;
      flag_d = flag_q;
      ien_d = ien_q;
      cp_d = cp_q;
      cp_init_d = 1'b1;
      bulk_d = bulk_q;
      lt_we = 1'b0;
      lt_waddr = addr_q[4:0];
      lt_wdata = data_q;
      tmr_start = 1'b0;
      tmr_ticks = PROG_TICKS;
      // Fuse level is caught after reset release, never by the reset itself
      if (!cp_init_q) begin
         cp_d = cfg_code_protect_in;
      end
      unique case (st_q)
         ST_IDLE: begin
            if (bus_w) begin
               // Any write other than the next key aborts, the trigger included
               key_d = KEY_IDLE;
               unique case (bus_in.addr)
                  OFS_KEY: begin
                     if (bus_in.wdata == KEY_FIRST) begin
                        key_d = KEY_ONE;
                     end else if (bus_in.wdata == KEY_SECOND && key_q == KEY_ONE) begin
                        key_d = KEY_TWO;
                     end
                  end
                  OFS_CTRL: begin
                     ctl_d = {bus_in.wdata[7:2], 2'b00};
                     if (bus_in.wdata[CTL_RD]) begin
                        ctl_d[CTL_RD] = 1'b1;
                        st_d = ST_RD;
                     end else if (bus_in.wdata[CTL_WR] && key_q == KEY_TWO &&
                                  bus_in.wdata[CTL_WALLOW]) begin
                        if (wr_refused(bus_in.wdata[CTL_SPACE], addr_q, cfg_wrt_in)) begin
                           ctl_d[CTL_WR] = 1'b0;
                        end else if (bus_in.wdata[CTL_ERASE]) begin
                           ctl_d[CTL_WR] = 1'b1;
                           idx_d = 14'h0000;
                           st_d = ST_ER;
                        end else begin
                           // Load the addressed latch; a full write then programs the row
                           lt_we = 1'b1;
                           if (!bus_in.wdata[CTL_LATCH]) begin
                              ctl_d[CTL_WR] = 1'b1;
                              idx_d = 14'h0000;
                              st_d = ST_PG_RD;
                           end
                        end
                     end
                  end
                  OFS_ADDR_LO: addr_d[7:0] = bus_in.wdata;
                  OFS_ADDR_HI: addr_d[14:8] = bus_in.wdata[6:0];
                  OFS_DATA_LO: data_d[7:0] = bus_in.wdata;
                  OFS_DATA_HI: data_d[13:8] = bus_in.wdata[5:0];
                  OFS_PTR_LO: ptr_d[7:0] = bus_in.wdata;
                  OFS_PTR_HI: ptr_d[15:8] = bus_in.wdata;
                  OFS_STATUS: begin
                     ien_d = bus_in.wdata[STS_IEN];
                     if (!bus_in.wdata[STS_FLAG]) begin
                        flag_d = 1'b0;
                     end
                  end
                  default: begin
                     // Indirect data port and unmapped offsets take no write
                  end
               endcase
            end else if (pgm_in.bulk) begin
               // Only the programmer can bulk erase; no self path reaches here
               idx_d = 14'h0000;
               st_d = ST_BULK;
            end
         end
         ST_RD: st_d = ST_RD_CAP;
         ST_RD_CAP: begin
            if (ctl_q[CTL_SPACE] && addr_q[14:4] == 11'h000 && addr_q[3:0] == REV_ADDR) begin
               data_d = REV_ID;
            end else if (ctl_q[CTL_SPACE] && addr_q[14:4] == 11'h000 &&
                         addr_q[3:0] == DEV_ADDR) begin
               data_d = DEV_ID;
            end else begin
               data_d = fl_rdata;
            end
            ctl_d[CTL_RD] = 1'b0;
            st_d = ST_IDLE;
         end
         ST_ER: begin
            idx_d = idx_q + 14'h0001;
            if (idx_q[4:0] == 5'h1f) begin
               tmr_start = 1'b1;
               tmr_ticks = ERASE_TICKS;
               st_d = ST_WAIT;
            end
         end
         ST_PG_RD: st_d = ST_PG_WR;
         ST_PG_WR: begin
            // Latches return to erased after being committed
            lt_we = 1'b1;
            lt_waddr = idx_q[4:0];
            lt_wdata = ERASED_WORD;
            idx_d = idx_q + 14'h0001;
            if (idx_q[4:0] == 5'h1f) begin
               tmr_start = 1'b1;
               tmr_ticks = PROG_TICKS;
               st_d = ST_WAIT;
            end else begin
               st_d = ST_PG_RD;
            end
         end
         ST_BULK: begin
            idx_d = idx_q + 14'h0001;
            if (idx_q == 14'h3fff) begin
               bulk_d = 1'b1;
               tmr_start = 1'b1;
               tmr_ticks = ERASE_TICKS;
               st_d = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (tmr_done) begin
               if (bulk_q) begin
                  cp_d = 1'b0;
                  bulk_d = 1'b0;
               end else begin
                  // Write-allow and latches stay as they are
                  flag_d = 1'b1;
                  ctl_d[CTL_WR] = 1'b0;
               end
               st_d = ST_IDLE;
            end
         end
      endcase
      // A completion in the same cycle as a software clear keeps the flag
      if (st_q == ST_WAIT && tmr_done && !bulk_q) begin
         flag_d = 1'b1;
      end
   end

   // Sequencer registers
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         st_q <= ST_IDLE;
         key_q <= KEY_IDLE;
         ctl_q <= CTRL_RESET;
         addr_q <= 15'h0000;
         data_q <= 14'h0000;
         ptr_q <= 16'h0000;
         idx_q <= 14'h0000;
         flag_q <= 1'b0;
         ien_q <= 1'b0;
         cp_q <= 1'b0;
         cp_init_q <= 1'b0;
         bulk_q <= 1'b0;
      end else begin
         st_q <= st_d;
         key_q <= key_d;
         ctl_q <= ctl_d;
         addr_q <= addr_d;
         data_q <= data_d;
         ptr_q <= ptr_d;
         idx_q <= idx_d;
         flag_q <= flag_d;
         ien_q <= ien_d;
         cp_q <= cp_d;
         cp_init_q <= cp_init_d;
         bulk_q <= bulk_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Array port steering
   always_comb begin
      fl_we = 1'b0;
      fl_waddr = {row_base[13:5], idx_q[4:0]};
      fl_wdata = ERASED_WORD;
      // Idle read port follows the pointer so a pointer read is ready unless a programmer read takes the port
      fl_raddr = {1'b0, ptr_d[12:0]};
      unique case (st_q)
         ST_RD: fl_raddr = arr_addr(ctl_q[CTL_SPACE], addr_q);
         ST_PG_RD: fl_raddr = {row_base[13:5], idx_q[4:0]};
         ST_ER: fl_we = 1'b1;
         ST_PG_WR: begin
            fl_we = 1'b1;
            fl_wdata = fl_rdata & lt_rdata;
         end
         ST_BULK: begin
            fl_we = 1'b1;
            fl_waddr = idx_q;
         end
         ST_IDLE: begin
            // Programmer writes and read data are blocked under code protection; bulk erase still runs
            if (pgm_in.rd) begin
               fl_raddr = pgm_in.addr;
            end
            if (pgm_in.wr && !cp_q && !bus_w) begin
               fl_we = 1'b1;
               fl_waddr = pgm_in.addr;
               fl_wdata = pgm_in.wdata;
            end
         end
         default: begin
            // Remaining states leave the array alone
         end
      endcase
   end

   pfa_mem #(.W(WORD_W), .AW(ARR_AW)) u_flash (
      .mclk_in(mclk_in),
      .we_in(fl_we),
      .waddr_in(fl_waddr),
      .wdata_in(fl_wdata),
      .raddr_in(fl_raddr),
      .rdata_out(fl_rdata)
   );

   pfa_mem #(.W(WORD_W), .AW(ROW_AW)) u_latch (
      .mclk_in(mclk_in),
      .we_in(lt_we),
      .waddr_in(lt_waddr),
      .wdata_in(lt_wdata),
      .raddr_in(idx_q[4:0]),
      .rdata_out(lt_rdata)
   );

   pfa_tmr u_tmr (
      .mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in),
      .start_in(tmr_start),
      .ticks_in(tmr_ticks),
      .done_out(tmr_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Read data, stall and interrupt outputs
   always_comb begin
      rdata_d = 8'h00;
      if (bus_r) begin
         unique case (bus_in.addr)
            OFS_CTRL: rdata_d = ctl_q;
            OFS_ADDR_LO: rdata_d = addr_q[7:0];
            OFS_ADDR_HI: rdata_d = {1'b0, addr_q[14:8]};
            OFS_DATA_LO: rdata_d = data_q[7:0];
            OFS_DATA_HI: rdata_d = {2'b00, data_q[13:8]};
            OFS_PTR_LO: rdata_d = ptr_q[7:0];
            OFS_PTR_HI: rdata_d = ptr_q[15:8];
            OFS_IND_DATA: rdata_d = fl_rdata[7:0];
            OFS_STATUS: rdata_d = {4'h0, cp_q, st_q != ST_IDLE, ien_q, flag_q};
            default: rdata_d = 8'h00;
         endcase
      end
      // Stall covers every sequencer cycle and the pointer read cycle
      stall_d = (st_d != ST_IDLE) || (bus_r && bus_in.addr == OFS_IND_DATA);
      irq_d = flag_d && ien_d;
      pgm_rdata_d = cp_q ? 14'h0000 : fl_rdata;
   end

   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rd_data_out <= 8'h00;
         cpu_stall_out <= 1'b0;
         irq_out <= 1'b0;
         pgm_rd_q <= 1'b0;
         pgm_rdata_out <= 14'h0000;
      end else begin
         rd_data_out <= rdata_d;
         cpu_stall_out <= stall_d;
         irq_out <= irq_d;
         pgm_rd_q <= pgm_in.rd && st_q == ST_IDLE;
         if (pgm_rd_q) begin
            pgm_rdata_out <= pgm_rdata_d;
         end
      end
   end

endmodule : pfa_ctrl

// ### pfa_ctrl_asserts.sv
// Port checker for the flash access controller.
// Assumes one clock and steady config inputs.
`timescale 1ns/1ps
module pfa_ctrl_asserts
   import pfa_pkg::*;
(
   input wire logic mclk_in, // Clock
   input wire logic sys_rst_in, // Reset
   input wire pfa_pkg::pfa_bus_t bus_in, // Register port
   input wire pfa_pkg::pfa_pgm_t pgm_in, // Programmer port
   input wire logic cpu_stall_out, // Suspend
   input wire logic irq_out, // Interrupt
   input wire logic [1:0] cfg_wrt_in // Protect range
);
   import pfa_pkg::*;
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);
   logic [1:0] key_q;
   logic [1:0] key_d;
   logic wr_ok;
   logic trig;
   assign wr_ok = bus_in.wr && !cpu_stall_out;
   assign trig = wr_ok && bus_in.addr == OFS_CTRL && bus_in.wdata[CTL_WR] && !bus_in.wdata[CTL_RD];
   // Key progress; any other taken write restarts it
   always_comb begin
      key_d = key_q;
      if (wr_ok) begin
         key_d = (bus_in.addr != OFS_KEY) ? 2'h0 : (bus_in.wdata == KEY_FIRST) ? 2'h1 :
            (bus_in.wdata == KEY_SECOND && key_q == 2'h1) ? 2'h2 : 2'h0;
      end
   end
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         key_q <= 2'h0;
      end else begin
         key_q <= key_d;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   property p_ptr;
      bus_in.rd && bus_in.addr == OFS_IND_DATA && !cpu_stall_out |=> cpu_stall_out ##1 !cpu_stall_out;
   endproperty
   a_ptr: assert property (p_ptr) else $error("pointer read stall wrong");
   property p_ind_wr;
      wr_ok && bus_in.addr == OFS_IND_DATA |=> !cpu_stall_out;
   endproperty
   a_ind_wr: assert property (p_ind_wr) else $error("pointer write started work");
   property p_rd_trig;
      wr_ok && bus_in.addr == OFS_CTRL && bus_in.wdata[CTL_RD] |=> cpu_stall_out[*2] ##1 !cpu_stall_out;
   endproperty
   a_rd_trig: assert property (p_rd_trig) else $error("read stall wrong");
   property p_no_key;
      trig && key_q != 2'h2 |=> !cpu_stall_out;
   endproperty
   a_no_key: assert property (p_no_key) else $error("locked trigger ran");
   property p_prot;
      trig && !bus_in.wdata[CTL_SPACE] && cfg_wrt_in == WRT_ALL |=> !cpu_stall_out;
   endproperty
   a_prot: assert property (p_prot) else $error("protected target changed");
   // Programmer bulk erase sweeps the whole array and is far longer than a row
   property p_bound;
      $rose(cpu_stall_out) && !$past(pgm_in.bulk) |-> ##[1:900] !cpu_stall_out;
   endproperty
   a_bound: assert property (p_bound) else $error("operation too long");
   property p_irq;
      $rose(irq_out) |-> $past(cpu_stall_out, 2) || $past(bus_in.wr);
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt without cause");
   property p_cause;
      $rose(cpu_stall_out) |-> $past(bus_in.wr) || $past(bus_in.rd) || $past(pgm_in.bulk);
   endproperty
   a_cause: assert property (p_cause) else $error("stall without request");
endmodule : pfa_ctrl_asserts
bind pfa_ctrl pfa_ctrl_asserts u_chk (.mclk_in, .sys_rst_in, .bus_in, .pgm_in, .cpu_stall_out,
   .irq_out, .cfg_wrt_in);

// ### pfa_cpu_model.sv
// CPU core model issuing register port requests.
// Assumes one task at a time from the bench.
`timescale 1ns/1ps
module pfa_cpu_model
   import pfa_pkg::*;
(
   input wire logic mclk_in, // Clock
   input wire logic stall_in, // Suspend
   input wire logic [7:0] rd_data_in, // Read data
   output pfa_pkg::pfa_bus_t bus_out // Request
);
   import pfa_pkg::*;
   pfa_bus_t bus_q = '0;
   assign bus_out = bus_q;
   // A suspended core issues nothing; idle fields flip so stale values never pass
   task automatic issue(input pfa_bus_t req);
      @(posedge mclk_in);
      while (stall_in) begin
         @(posedge mclk_in);
      end
      bus_q <= req;
      @(posedge mclk_in);
      bus_q <= {2'h0, ~req.addr, ~req.wdata};
   endtask : issue
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      issue({2'h2, a, d});
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      issue({2'h1, a, 8'h00});
      @(posedge mclk_in);
      d = rd_data_in;
   endtask : rd
   // Interrupt enable is left as it is; write-allow rides in ctl
   task automatic unlock(input logic [7:0] ctl);
      wr(OFS_KEY, KEY_FIRST);
      wr(OFS_KEY, KEY_SECOND);
      wr(OFS_CTRL, ctl);
   endtask : unlock
endmodule : pfa_cpu_model

// ### pfa_ctrl_bench.sv
// Bench for the flash access controller.
// Assumes a bulk erase leaves the array clean.
`timescale 1ns/1ps
module pfa_ctrl_bench;
   import pfa_pkg::*;
   localparam logic [13:0] REV_CODE = 14'h1357; // Arbitrary value
   logic mclk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [1:0] cfg_wrt_in = 2'h3;
   logic cfg_code_protect_in = 1'b0;
   pfa_pgm_t pgm_in = '0;
   pfa_bus_t bus_in;
   logic [7:0] rd_data_out;
   logic cpu_stall_out;
   logic irq_out;
   logic [7:0] b;
   logic [13:0] pgm_rdata_out;
   int n_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   pfa_ctrl #(.REV_ID(REV_CODE)) dut (.mclk_in, .sys_rst_in, .bus_in, .rd_data_out,
      .cpu_stall_out, .irq_out, .cfg_wrt_in, .cfg_code_protect_in, .pgm_in, .pgm_rdata_out);
   pfa_cpu_model cpu (.mclk_in, .stall_in(cpu_stall_out), .rd_data_in(rd_data_out),
      .bus_out(bus_in));
   initial begin
      forever #2.5 mclk_in = ~mclk_in;
   end
   // Hang guard, far above the bulk erase and all operations
   always @(posedge mclk_in) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         n_errors = n_errors + 1;
         $display("unexpected at %0t: timeout", $time);
         tally_and_finish();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : tally_and_finish
   task automatic check(input logic [13:0] got, input logic [13:0] exp);
      total_checks = total_checks + 1;
      if (got !== exp) begin
         n_errors = n_errors + 1;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : check
   task automatic put(input logic [13:0] a, input logic [13:0] d);
      cpu.wr(OFS_ADDR_LO, a[7:0]);
      cpu.wr(OFS_ADDR_HI, {2'h0, a[13:8]});
      cpu.wr(OFS_DATA_LO, d[7:0]);
      cpu.wr(OFS_DATA_HI, {2'h0, d[13:8]});
   endtask : put
   task automatic rw(input logic [13:0] a, input logic sp, input logic [13:0] exp);
      logic [7:0] lo;
      put(a, 14'h0000);
      cpu.wr(OFS_CTRL, {1'b0, sp, 6'h01});
      cpu.rd(OFS_DATA_LO, lo);
      cpu.rd(OFS_DATA_HI, b);
      check({b[5:0], lo}, exp);
   endtask : rw
   task automatic t_read();
      rw(14'h0005, 1'b1, REV_CODE);
      cpu.rd(OFS_CTRL, b);
      check({6'h0, b}, 14'h0040);
      rw(14'h0123, 1'b0, ERASED_WORD);
   endtask : t_read
   task automatic t_program();
      for (int i = 0; i < 32; i++) begin
         put(14'h0040 + 14'(i), (i == 3) ? 14'h1234 : (i == 31) ? 14'h0abc : 14'h3fff);
         cpu.unlock((i == 31) ? 8'h06 : 8'h16);
      end
      rw(14'h0043, 1'b0, 14'h1234);
      rw(14'h005f, 1'b0, 14'h0abc);
      cpu.rd(OFS_STATUS, b);
      check({6'h0, b}, 14'h0001);
      put(14'h0043, 14'h0ff0);
      cpu.unlock(8'h06);
      rw(14'h0043, 1'b0, 14'h0230);
   endtask : t_program
   task automatic t_pointer();
      cpu.wr(OFS_PTR_LO, 8'h43);
      cpu.wr(OFS_PTR_HI, 8'h00);
      cpu.rd(OFS_IND_DATA, b);
      check({6'h0, b}, 14'h0030);
      cpu.wr(OFS_IND_DATA, 8'h00);
      rw(14'h0043, 1'b0, 14'h0230);
   endtask : t_pointer
   task automatic t_erase();
      cpu.wr(OFS_STATUS, 8'h02);
      put(14'h0045, 14'h0000);
      cpu.unlock(8'h0e);
      cpu.rd(OFS_CTRL, b);
      check({6'h0, b}, 14'h000c);
      check({13'h0, irq_out}, 14'h0001);
      rw(14'h0043, 1'b0, ERASED_WORD);
      cpu.wr(OFS_STATUS, 8'h02);
      cpu.rd(OFS_STATUS, b);
      check({5'h0, irq_out, b}, 14'h0002);
   endtask : t_erase
   task automatic t_refuse();
      put(14'h0060, 14'h0000);
      cpu.wr(OFS_KEY, KEY_SECOND);
      cpu.wr(OFS_KEY, KEY_FIRST);
      cpu.wr(OFS_CTRL, 8'h06);
      cpu.wr(OFS_CTRL, 8'h06);
      @(posedge mclk_in);
      cfg_wrt_in <= WRT_ALL;
      cpu.unlock(8'h06);
      cpu.rd(OFS_CTRL, b);
      check({6'h0, b}, 14'h0004);
      cfg_wrt_in <= 2'h3;
      rw(14'h0060, 1'b0, ERASED_WORD);
      cpu.rd(OFS_STATUS, b);
      check({6'h0, b}, 14'h0002);
   endtask : t_refuse
   ////////////////////////////////////////////////////////////////////////////
   // Reset, bulk erase, then the scenarios
   initial begin
      repeat (8) @(posedge mclk_in);
      sys_rst_in <= 1'b0;
      @(posedge mclk_in);
      pgm_in.bulk <= 1'b1;
      @(posedge mclk_in);
      pgm_in.bulk <= 1'b0;
      repeat (17600) @(posedge mclk_in);
      // Unprotected programmer read of word 0 after the bulk erase
      pgm_in.rd <= 1'b1;
      @(posedge mclk_in);
      pgm_in.rd <= 1'b0;
      repeat (2) @(posedge mclk_in);
      check(pgm_rdata_out, ERASED_WORD);
      t_read();
      t_program();
      t_pointer();
      t_erase();
      t_refuse();
      tally_and_finish();
   end
endmodule : pfa_ctrl_bench
